// *** core/scr_pkg.sv ***
// package of constants plus the sticky event flag module for the serial unit config block
`timescale 1ns/1ps
`default_nettype none
package scr_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_RCFG   = 8'h04;
  localparam logic [7:0] OFF_RCNT   = 8'h08;
  localparam logic [7:0] OFF_TCFG   = 8'h0C;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_TXDATA = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h1C;
  // ------------------------------------------------------------
  // field positions, write masks, reset values
  // ------------------------------------------------------------
  localparam int         MODE_PROTO_LSB = 4;
  localparam int         MODE_SUBM_LSB  = 2;
  localparam int         MODE_CLKS_LSB  = 0;
  localparam int         RCFG_SYNC_BIT  = 6;
  localparam int         RCFG_RPOL_BIT  = 5;
  localparam int         RCNT_CRS_LSB   = 5;
  localparam int         TCFG_EN_BIT    = 7;
  localparam int         TCFG_TPOL_BIT  = 5;
  localparam int         CNT_W          = 5;
  localparam logic [7:0] RCFG_WMASK     = 8'h7F;
  localparam logic [7:0] TCFG_WMASK     = 8'hBF;
  localparam logic [7:0] MODE_RST       = 8'h00;
  localparam logic [7:0] RCFG_RST       = 8'h00;
  localparam logic [1:0] CRS_RST        = 2'h0;
  localparam logic [7:0] TCFG_RST       = 8'h00;
  localparam logic [3:0] MASK_RST       = 4'h0;
  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [3:0] PROTO_OFF  = 4'h0;
  localparam logic [3:0] PROTO_ETH  = 4'h1;
  localparam logic [3:0] PROTO_USB  = 4'h2;
  localparam logic [3:0] PROTO_UART = 4'h3;
  localparam logic [3:0] PROTO_I2C  = 4'h4;
  localparam logic [3:0] PROTO_SPI  = 4'h5;
  localparam logic [1:0] SUBM_USB_LOW  = 2'h1;
  localparam logic [1:0] SUBM_USB_HIGH = 2'h2;
  localparam logic [1:0] CLKS_OFF  = 2'h0;
  localparam logic [1:0] CLKS_RSVD = 2'h1;
  localparam logic [1:0] CLKS_OSC  = 2'h2;
  localparam logic [1:0] CLKS_PLL  = 2'h3;
  localparam logic [1:0] CRS_ON_DETECT = 2'h2;
  localparam logic [1:0] CRS_ON_LOSS   = 2'h3;
  // value arbitrary, a neutral sync pattern
  localparam logic [7:0] SYNC_PATTERN  = 8'hA7;
  // ------------------------------------------------------------
  // event flags and bus
  // ------------------------------------------------------------
  localparam int         EV_RX_DONE   = 0;
  localparam int         EV_TX_DONE   = 1;
  localparam int         EV_CARRIER   = 2;
  localparam int         EV_SYNC      = 3;
  localparam int         EV_W         = 4;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RRESP = 3'b100
  } scr_bus_st_t;
endpackage : scr_pkg
`default_nettype wire

`default_nettype none
module scr_sticky #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] flags;
  } scr_sticky_t;

  scr_sticky_t s_q;
  scr_sticky_t s_d;

  // set wins over a clear in the same cycle
  always_comb begin
    s_d       = s_q;
    s_d.flags = (s_q.flags & ~clr) | set;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.flags;
endmodule : scr_sticky
`default_nettype wire

// *** core/scr_config_regs.sv ***
// serial unit configuration registers with bit counters, axi4-lite slave
// How it works
// RULE1: protocol field picks line protocol, others reserved
// RULE2: usb submode 01 low, 10 high speed
// RULE3: spi submode sets receive and transmit edges
// RULE4: clock source 00 stops, 01 reserved, osc, pll
// RULE5: sync bit 0 enables, 1 disables detection
// RULE6: receive polarity bit inverts received bits
// RULE7: receive count sets bits per received word
// RULE8: actual received bit count readable, write ignored
// RULE9: carrier control 0x none, 10 detect, 11 loss
// RULE10: transmit polarity bit inverts sent bits
// RULE11: transmit count sets bits sent per word
// RULE12: enable bit gates the whole unit; code gates only receive and transmit, carrier events and mode outputs run
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs
  import scr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        line_rx_bit,
  input  wire logic        line_rx_strobe,
  input  wire logic        line_carrier,
  input  wire logic        line_tx_strobe,
  output logic             line_tx_bit,
  output logic [3:0]       protocol_select,
  output logic             usb_low_speed,
  output logic             usb_high_speed,
  output logic             spi_rx_rising,
  output logic             spi_tx_rising,
  output logic             clk_run_osc,
  output logic             clk_run_pll,
  output logic             unit_active,
  output logic             irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    scr_bus_st_t st;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        bvalid;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [7:0]  mode;
    logic [7:0]  rcfg;
    logic [1:0]  crs_ctrl;
    logic [7:0]  tcfg;
    logic [EV_W-1:0] mask;
    logic [CNT_W-1:0] rx_cnt;
    logic [31:0] rx_shift;
    logic [31:0] rx_data;
    logic        tx_busy;
    logic [CNT_W-1:0] tx_cnt;
    logic [31:0] tx_shift;
    logic        line_tx;
    logic        crs;
    logic        usb_low;
    logic        usb_high;
    logic        spi_rx_r;
    logic        spi_tx_r;
    logic        clk_osc;
    logic        clk_pll;
    logic        active;
    logic        irq;
  } scr_regs_t;

  localparam scr_regs_t REGS_RST = '{
    st: BUS_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
    bresp: RESP_OKAY, rresp: RESP_OKAY, mode: MODE_RST, rcfg: RCFG_RST,
    crs_ctrl: CRS_RST, tcfg: TCFG_RST, mask: MASK_RST, default: '0
  };

  scr_regs_t s_q;
  scr_regs_t s_d;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] st_clr;
  logic [EV_W-1:0] flags_q;
  logic            aw_hs;
  logic            w_hs;
  logic            ar_hs;

  assign aw_hs = s_axi_awvalid & s_q.awready;
  assign w_hs  = s_axi_wvalid & s_q.wready;
  assign ar_hs = s_axi_arvalid & s_q.arready;

  scr_sticky #(.W(EV_W)) u_flags (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .set     (ev_set),
    .clr     (st_clr),
    .q       (flags_q)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] bmask;
    logic [3:0]  proto;
    logic        rbit;
    bmask  = '0;
    proto  = '0;
    rbit   = 1'b0;
    s_d    = s_q;
    ev_set = '0;
    st_clr = '0;
    unique case (s_q.st)
      BUS_IDLE: begin
        if (aw_hs) begin
          s_d.aw_got = 1'b1;
          s_d.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
          s_d.w_got = 1'b1;
          s_d.wdata = s_axi_wdata;
          s_d.wstrb = s_axi_wstrb;
        end
        if (ar_hs) begin
          s_d.st     = BUS_RRESP;
          s_d.rvalid = 1'b1;
          s_d.rresp  = RESP_OKAY;
          s_d.rdata  = '0;
          case ({s_axi_araddr[7:2], 2'b00})
            OFF_MODE:   s_d.rdata[7:0] = s_q.mode;
            OFF_RCFG:   s_d.rdata[7:0] = s_q.rcfg;
            OFF_RCNT:   s_d.rdata[7:0] = {1'b0, s_q.crs_ctrl, s_q.rx_cnt}; // RULE8
            OFF_TCFG:   s_d.rdata[7:0] = s_q.tcfg;
            OFF_RXDATA: s_d.rdata = s_q.rx_data;
            OFF_TXDATA: s_d.rdata = s_q.tx_shift;
            OFF_STATUS: begin
              s_d.rdata[EV_W:0] = {s_q.crs, flags_q}; // RULE9
              st_clr = '1;
            end
            OFF_MASK:   s_d.rdata[EV_W-1:0] = s_q.mask;
            default:    s_d.rresp = RESP_SLVERR;
          endcase
        end else if (s_d.aw_got && s_d.w_got) begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.st     = BUS_WRESP;
          s_d.bvalid = 1'b1;
          s_d.bresp  = RESP_OKAY;
          for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{s_d.wstrb[i]}};
          end
          case ({s_d.awaddr[7:2], 2'b00})
            OFF_MODE: if (s_d.wstrb[0]) begin
              s_d.mode = s_d.wdata[7:0];
            end
            OFF_RCFG: if (s_d.wstrb[0]) begin
              s_d.rcfg = s_d.wdata[7:0] & RCFG_WMASK;
            end
            OFF_RCNT: if (s_d.wstrb[0]) begin
              s_d.crs_ctrl = s_d.wdata[RCNT_CRS_LSB +: 2]; // RULE8
            end
            OFF_TCFG: if (s_d.wstrb[0]) begin
              s_d.tcfg = s_d.wdata[7:0] & TCFG_WMASK;
            end
            OFF_TXDATA: if (!s_q.tx_busy) begin
              s_d.tx_shift = s_d.wdata & bmask;
              s_d.tx_busy  = 1'b1;
              s_d.tx_cnt   = '0;
            end
            OFF_MASK: if (s_d.wstrb[0]) begin
              s_d.mask = s_d.wdata[EV_W-1:0];
            end
            OFF_RXDATA, OFF_STATUS: ;
            default: s_d.bresp = RESP_SLVERR;
          endcase
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.st     = BUS_IDLE;
        end
      end
      BUS_RRESP: begin
        if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.st     = BUS_IDLE;
        end
      end
    endcase
    s_d.awready = (s_d.st == BUS_IDLE) && !s_d.aw_got;
    s_d.wready  = (s_d.st == BUS_IDLE) && !s_d.w_got;
    s_d.arready = (s_d.st == BUS_IDLE);

    // deserializer
    proto = s_q.mode[MODE_PROTO_LSB +: 4];
    if (!s_q.active) begin
      s_d.rx_cnt = '0;
    end else if (line_rx_strobe) begin
      rbit         = line_rx_bit ^ s_q.rcfg[RCFG_RPOL_BIT]; // RULE6
      s_d.rx_shift = {s_q.rx_shift[30:0], rbit};
      if (s_q.rx_cnt == s_q.rcfg[CNT_W-1:0] - 5'h01) begin // RULE7
        s_d.rx_cnt          = '0;
        s_d.rx_data         = s_d.rx_shift;
        ev_set[EV_RX_DONE]  = 1'b1;
      end else begin
        s_d.rx_cnt = s_q.rx_cnt + 5'h01; // RULE8
      end
      if (!s_q.rcfg[RCFG_SYNC_BIT] && (proto == PROTO_ETH || proto == PROTO_USB)
          && s_d.rx_shift[7:0] == SYNC_PATTERN) begin // RULE5
        ev_set[EV_SYNC] = 1'b1;
      end
    end

    // serializer
    if (s_q.active && s_q.tx_busy && line_tx_strobe) begin
      s_d.line_tx  = s_q.tx_shift[0] ^ s_q.tcfg[TCFG_TPOL_BIT]; // RULE10
      s_d.tx_shift = {1'b0, s_q.tx_shift[31:1]};
      if (s_q.tx_cnt == s_q.tcfg[CNT_W-1:0] - 5'h01) begin // RULE11
        s_d.tx_busy        = 1'b0;
        s_d.tx_cnt         = '0;
        ev_set[EV_TX_DONE] = 1'b1;
      end else begin
        s_d.tx_cnt = s_q.tx_cnt + 5'h01;
      end
    end else if (!s_q.tx_busy) begin
      s_d.line_tx = s_q.tcfg[TCFG_TPOL_BIT];
    end

    // carrier sense
    s_d.crs = line_carrier;
    if ((s_q.crs_ctrl == CRS_ON_DETECT && line_carrier && !s_q.crs) ||
        (s_q.crs_ctrl == CRS_ON_LOSS && !line_carrier && s_q.crs)) begin // RULE9
      ev_set[EV_CARRIER] = 1'b1;
    end

    // mode decode from the new register values
    proto        = s_d.mode[MODE_PROTO_LSB +: 4];
    s_d.usb_low  = proto == PROTO_USB && s_d.mode[MODE_SUBM_LSB +: 2] == SUBM_USB_LOW; // RULE2
    s_d.usb_high = proto == PROTO_USB && s_d.mode[MODE_SUBM_LSB +: 2] == SUBM_USB_HIGH; // RULE2
    s_d.spi_rx_r = proto == PROTO_SPI && s_d.mode[MODE_SUBM_LSB];       // RULE3
    s_d.spi_tx_r = proto == PROTO_SPI && !s_d.mode[MODE_SUBM_LSB + 1];  // RULE3
    s_d.clk_osc  = s_d.mode[MODE_CLKS_LSB +: 2] == CLKS_OSC; // RULE4
    s_d.clk_pll  = s_d.mode[MODE_CLKS_LSB +: 2] == CLKS_PLL; // RULE4
    s_d.active   = s_d.tcfg[TCFG_EN_BIT] && proto != PROTO_OFF && proto <= PROTO_SPI
                   && (s_d.clk_osc || s_d.clk_pll); // RULE1 RULE12
    s_d.irq      = |(flags_q & s_q.mask);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= REGS_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready   = s_q.awready;
  assign s_axi_wready    = s_q.wready;
  assign s_axi_arready   = s_q.arready;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_rvalid    = s_q.rvalid;
  assign s_axi_rresp     = s_q.rresp;
  assign s_axi_rdata     = s_q.rdata;
  assign line_tx_bit     = s_q.line_tx;
  assign protocol_select = s_q.mode[MODE_PROTO_LSB +: 4];
  assign usb_low_speed   = s_q.usb_low;
  assign usb_high_speed  = s_q.usb_high;
  assign spi_rx_rising   = s_q.spi_rx_r;
  assign spi_tx_rising   = s_q.spi_tx_r;
  assign clk_run_osc     = s_q.clk_osc;
  assign clk_run_pll     = s_q.clk_pll;
  assign unit_active     = s_q.active;
  assign irq             = s_q.irq;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_proto_valid: assert property (unit_active |-> protocol_select inside {[PROTO_ETH:PROTO_SPI]}) // RULE1
    else $error("unit active with disabled or reserved protocol");
  a_usb_speed: assert property ( // RULE2
    (usb_low_speed || usb_high_speed) |-> protocol_select == PROTO_USB && !(usb_low_speed && usb_high_speed))
    else $error("usb speed outputs inconsistent with mode");
  a_spi_edges: assert property (protocol_select == PROTO_SPI |-> // RULE3
    spi_rx_rising == s_q.mode[MODE_SUBM_LSB] && spi_tx_rising == !s_q.mode[MODE_SUBM_LSB + 1])
    else $error("spi edge outputs do not follow submode");
  a_clk_stop: assert property (!s_q.mode[MODE_CLKS_LSB + 1] |-> !clk_run_osc && !clk_run_pll && !unit_active) // RULE4
    else $error("unit clock running with source off or reserved");
  a_sync_gate: assert property (ev_set[EV_SYNC] |-> !s_q.rcfg[RCFG_SYNC_BIT]) // RULE5
    else $error("sync event while detection disabled");
  a_rx_invert: assert property (clk_en && unit_active && line_rx_strobe |=> // RULE6
    s_q.rx_shift[0] == $past(line_rx_bit ^ s_q.rcfg[RCFG_RPOL_BIT]))
    else $error("received bit polarity wrong");
  a_rx_word: assert property (ev_set[EV_RX_DONE] |-> s_q.rx_cnt == s_q.rcfg[CNT_W-1:0] - 5'h01) // RULE7
    else $error("receive word completed at wrong count");
  a_rx_count_hold: assert property (clk_en && unit_active && !line_rx_strobe |=> $stable(s_q.rx_cnt)) // RULE8
    else $error("actual receive count changed without a bit");
  a_crs_quiet: assert property (!s_q.crs_ctrl[1] |-> !ev_set[EV_CARRIER]) // RULE9
    else $error("carrier event while carrier interrupt off");
  a_tx_invert: assert property (clk_en && unit_active && s_q.tx_busy && line_tx_strobe |=> // RULE10
    line_tx_bit == $past(s_q.tx_shift[0] ^ s_q.tcfg[TCFG_TPOL_BIT]))
    else $error("sent bit polarity wrong");
  a_tx_count: assert property (ev_set[EV_TX_DONE] |-> s_q.tx_cnt == s_q.tcfg[CNT_W-1:0] - 5'h01) // RULE11
    else $error("transmit word ended at wrong count");
  a_enable_gate: assert property (!s_q.tcfg[TCFG_EN_BIT] |-> !unit_active) // RULE12
    else $error("unit active while disabled");

  c_rx_word: cover property (ev_set[EV_RX_DONE]);
  c_tx_word: cover property (ev_set[EV_TX_DONE]);
  c_sync: cover property (ev_set[EV_SYNC]);
  c_carrier: cover property (ev_set[EV_CARRIER] ##1 irq);
endmodule : scr_config_regs
`default_nettype wire

// *** testbench/scr_line_model.sv ***
// far-side serial line model: bit strobes, carrier level, transmit capture
`timescale 1ns/1ps
`default_nettype none
module scr_line_model (
  input  wire logic sys_clk,
  input  wire logic line_tx_bit,
  output var  logic line_rx_bit,
  output var  logic line_rx_strobe,
  output var  logic line_carrier,
  output var  logic line_tx_strobe
);
  initial begin
    line_rx_bit = 1'h0;
    line_rx_strobe = 1'h0;
    line_carrier = 1'h0;
    line_tx_strobe = 1'h0;
  end
  // ------------------------------------------------------------
  // line actions
  // ------------------------------------------------------------
  // data flips once the strobe is gone, so a stale value never looks valid
  task automatic send_bit(input logic b);
    @(posedge sys_clk);
    line_rx_bit <= b;
    line_rx_strobe <= 1'h1;
    @(posedge sys_clk);
    line_rx_bit <= ~b;
    line_rx_strobe <= 1'h0;
  endtask
  task automatic take_bit(output logic b);
    @(posedge sys_clk);
    line_tx_strobe <= 1'h1;
    @(posedge sys_clk);
    line_tx_strobe <= 1'h0;
    // launched on the previous edge, settled by this one
    @(posedge sys_clk);
    b = line_tx_bit;
  endtask
  task automatic set_carrier(input logic c);
    @(posedge sys_clk);
    line_carrier <= c;
  endtask
endmodule // scr_line_model
`default_nettype wire

// *** testbench/test_scr_config_regs.sv ***
// self-checking testbench of the serial unit configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_scr_config_regs
  import scr_pkg::*;
;
  typedef struct packed {logic [1:0] r; logic [31:0] d; logic [31:0] m;} scr_exp_t;
  logic        sys_clk = 1'h0, reset_n = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rnd = 8'h04;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, w;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, b;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        line_rx_bit, line_rx_strobe, line_carrier, line_tx_strobe, line_tx_bit;
  logic [3:0]  protocol_select;
  logic        usb_low_speed, usb_high_speed, spi_rx_rising, spi_tx_rising;
  logic        clk_run_osc, clk_run_pll, unit_active, irq;
  logic [10:0] x;
  wire  logic [10:0] outs;
  scr_exp_t    exp_q[$];
  scr_exp_t    e;
  int          n_errors = 0, cmp_count = 0;
  assign outs = {protocol_select, usb_low_speed, usb_high_speed, spi_rx_rising, spi_tx_rising,
                 clk_run_osc, clk_run_pll, unit_active};
  always #2 sys_clk = ~sys_clk;
  scr_config_regs uut (.sys_clk, .reset_n, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_rx_bit,
    .line_rx_strobe, .line_carrier, .line_tx_strobe, .line_tx_bit, .protocol_select, .usb_low_speed,
    .usb_high_speed, .spi_rx_rising, .spi_tx_rising, .clk_run_osc, .clk_run_pll, .unit_active, .irq);
  scr_line_model far (.sys_clk, .line_tx_bit, .line_rx_bit, .line_rx_strobe, .line_carrier,
    .line_tx_strobe);
  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] ex);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, (a > OFF_MASK) ? RESP_SLVERR : RESP_OKAY);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF);
    exp_q.push_back('{(a > OFF_MASK) ? RESP_SLVERR : RESP_OKAY, d, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({s_axi_rresp, s_axi_rdata & e.m}, {e.r, e.d & e.m});
    end
  end
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    chk(outs, 11'h0);
    for (int a = 0; a < 36; a += 4) rd(a[7:0], 32'h0);
    wr(8'h20, 32'hFF);
    wr(OFF_RCFG, 32'hFF);
    rd(OFF_RCFG, 32'h7F);
    wr(OFF_RCNT, 32'hFF);
    rd(OFF_RCNT, 32'h60);
    wr(OFF_TCFG, 32'hFF);
    rd(OFF_TCFG, 32'hBF);
    for (int p = 0; p < 7; p++) begin
      for (int s = 0; s < 4; s++) begin
        wr(OFF_MODE, p * 16 + s * 5);
        rd(OFF_MODE, p * 16 + s * 5);
        x = {p[3:0], p == 2 && s == 1, p == 2 && s == 2, p == 5 && s[0], p == 5 && !s[1], s == 2, s == 3,
             p > 0 && p < 6 && s > 1};
        chk(outs, x);
      end
    end
    // receive: inverted bits, count of eight, irq masked then unmasked
    wr(OFF_MODE, 32'h32);
    wr(OFF_RCFG, 32'h28);
    wr(OFF_MASK, 32'h0);
    w = 32'h0;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      far.send_bit(rnd[0]);
      w = {w[30:0], ~rnd[0]};
      if (i == 4) begin
        wr(OFF_RCNT, 32'h1F);
        rd(OFF_RCNT, 32'h5);
      end
    end
    rd(OFF_RCNT, 32'h0);
    rd(OFF_RXDATA, w, 32'hFF);
    chk(irq, 1'h0);
    wr(OFF_MASK, 32'h1);
    chk(irq, 1'h1);
    rd(OFF_STATUS, 32'h1, 32'h1);
    chk(irq, 1'h0);
    // transmit: four bits plain then inverted, then idle level
    for (int v = 0; v < 2; v++) begin
      wr(OFF_TCFG, 32'h84 + v * 32);
      rnd = lfsr(rnd);
      wr(OFF_TXDATA, {rnd[7:5], 1'h1, rnd[3:0]});
      for (int i = 0; i < 4; i++) begin
        far.take_bit(b);
        chk(b, rnd[i] ^ v[0]);
      end
      far.take_bit(b);
      chk(b, v[0]);
      rd(OFF_STATUS, 32'h2, 32'h2);
    end
    // carrier control codes 10, 11, 00, 01
    wr(OFF_MASK, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_RCNT, ((i + 2) % 4) * 32);
      far.set_carrier(!i[0]);
      repeat (3) @(posedge sys_clk);
      chk(irq, i < 2);
      rd(OFF_STATUS, (i < 2) * 4 + (!i[0]) * 16, 32'h14);
    end
    // sync pattern with detection on, then off
    wr(OFF_MODE, 32'h12);
    for (int d = 0; d < 2; d++) begin
      wr(OFF_RCFG, d * 64 + 8);
      rd(OFF_STATUS, 32'h0);
      for (int i = 7; i >= 0; i--) far.send_bit(SYNC_PATTERN[i]);
      rd(OFF_STATUS, (1 - d) * 8, 32'h8);
    end
    // unit disabled ignores line traffic
    wr(OFF_TCFG, 32'h24);
    far.send_bit(1'h1);
    rd(OFF_RCNT, 32'h0, 32'h1F);
    chk(unit_active, 1'h0);
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule // test_scr_config_regs
`default_nettype wire
